// ---- rtl/irac_top.sv ----
/*
  ir ambient adc configuration block: axi4-lite register slave holding the
  ir integration scale, conversion options and recovery period, a conversion
  pacer and an open-drain interrupt pin driver.
  assumes a single 100 MHz clock, synchronous reset, and an external pull-up
  on the interrupt line.
*/
//
// Overview of operation
// R1: integration time grows by two to scale
// R2: scale codes 0..7, factor up to 128
// R3: scale exists from sequencer revision A03 on
// R4: scale resets to zero, divide by one
// R5: bit 5 selects high range, gain/14.5
// R6: host keeps reserved option bits unchanged
// R7: interrupt pin open-drain, low or released
// R8: interrupt pin held high during power-up
// R9: host sets recovery to complement of scale
`timescale 1ns/10ps
module irac_top import irac_pkg::*; #(
  parameter logic [3:0] SEQ_REV = IRAC_SEQ_REV_A03,
  parameter int CNT_W = 24
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [9:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [9:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_event,
  input wire logic i_int_pin,
  output logic o_int_pin,
  output logic o_int_pin_oe_n,
  output logic o_high_range,
  output logic [IRAC_SCALE_W-1:0] o_scale,
  output logic o_conv_busy,
  output logic o_conv_done,
  output logic o_low_power_ok
);

  // ==========================================================
  // state
  // ==========================================================
  // every register of the block outside the pacer lives in this one struct
  typedef struct packed {
    logic aw_have; // write address held
    irac_wreq_type wreq; // captured write request
    logic w_have; // write data held
    logic bvalid; // write response pending
    logic [1:0] bresp; // write response code
    logic rvalid; // read data pending
    logic [31:0] rdata; // read data
    logic [1:0] rresp; // read response code
    logic [7:0] scale; // ir_integration_scale_param
    logic [7:0] options; // ir_conversion_options_param
    logic [7:0] recovery; // recovery period parameter
    logic conv_pend; // conversion request waiting
    logic int_low; // interrupt pin pulled low
    logic [1:0] pin_sync; // interrupt pin synchroniser
    logic pwrup_done; // power-up window closed
    logic [1:0] pwrup_age; // edges since reset, lets the synchroniser fill
    logic low_power_ok; // pin stayed high through power-up
  } irac_regs_type;

  irac_regs_type s_q;
  irac_regs_type s_d;
  logic t_busy; // timer running
  logic t_done; // conversion finished pulse
  logic t_start; // start a conversion
  logic scale_present; // scale parameter implemented on this revision
  logic [9:0] waddr; // effective write address
  logic [31:0] wdata; // effective write data
  // the pin is trusted only once both synchroniser stages hold real samples
  localparam logic [1:0] PWRUP_SETTLE = 2'h2;

  // scale parameter only exists from revision A03 onward
  assign scale_present = (SEQ_REV >= IRAC_SEQ_REV_A03); // R3
  // a request made while the pacer runs waits until it is idle
  assign t_start = s_q.conv_pend && !t_busy;
  // commit uses the held copy, so the bus may move on meanwhile
  assign waddr = s_q.wreq.addr;
  assign wdata = s_q.wreq.data;

  // ==========================================================
  // conversion pacer
  // ==========================================================
  irac_conv_timer #(
    .SCALE_W(IRAC_SCALE_W),
    .CNT_W(CNT_W)
  ) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_start(t_start),
    .i_scale(s_q.scale[IRAC_SCALE_W-1:0]),
    .i_recovery(s_q.recovery[IRAC_REC_LSB +: 3]),
    .o_busy(t_busy),
    .o_recovering(),
    .o_done(t_done)
  );

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    // by default every register holds its value
    s_d = s_q;
    // take address and data independently, in either order
    if (i_s_axi_awvalid && !s_q.aw_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b1;
      s_d.wreq.addr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && !s_q.w_have && !s_q.bvalid) begin
      s_d.w_have = 1'b1;
      s_d.wreq.data = i_s_axi_wdata;
      s_d.wreq.strb = i_s_axi_wstrb;
    end
    // commit once both halves are held
    if (s_q.aw_have && s_q.w_have) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = IRAC_RESP_OKAY;
      if (!s_q.wreq.strb[0]) begin
        // no low byte lane, nothing to store
      end else if (waddr == IRAC_ADDR_SCALE && scale_present) begin
        // only bits 2:0 hold; codes 0..7 give divide 1..128
        s_d.scale = wdata[7:0] & IRAC_SCALE_MASK; // R1 R2
      end else if (waddr == IRAC_ADDR_OPTIONS) begin
        // reserved bits are stored as written; host must preserve them
        s_d.options = wdata[7:0]; // R5 R6
      end else if (waddr == IRAC_ADDR_RECOVERY) begin
        s_d.recovery = wdata[7:0] & IRAC_REC_MASK; // R9
      end else if (waddr == IRAC_ADDR_STATUS) begin
        // writing bit 0 queues a conversion, bit 1 releases the pin
        if (wdata[0]) begin
          s_d.conv_pend = 1'b1;
        end
        if (wdata[1]) begin
          s_d.int_low = 1'b0;
        end
      end else begin
        // unmapped place: answer with an error, store nothing
        s_d.bresp = IRAC_RESP_SLVERR;
      end
    end
    // the response stands until the host takes it
    if (s_q.bvalid && i_s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // read channel: one read outstanding
    if (i_s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = IRAC_RESP_OKAY;
      s_d.rdata = '0;
      if (i_s_axi_araddr == IRAC_ADDR_SCALE && scale_present) begin
        s_d.rdata[7:0] = s_q.scale;
      end else if (i_s_axi_araddr == IRAC_ADDR_OPTIONS) begin
        s_d.rdata[7:0] = s_q.options;
      end else if (i_s_axi_araddr == IRAC_ADDR_RECOVERY) begin
        s_d.rdata[7:0] = s_q.recovery;
      end else if (i_s_axi_araddr == IRAC_ADDR_STATUS) begin
        // status packs the pin and pacer flags
        s_d.rdata[3:0] = {s_q.low_power_ok, s_q.int_low, t_busy, s_q.conv_pend};
      end else begin
        // unmapped place reads as zero with an error
        s_d.rresp = IRAC_RESP_SLVERR;
      end
    end else if (s_q.rvalid && i_s_axi_rready) begin
      // read data stands until taken
      s_d.rvalid = 1'b0;
    end
    // conversion hand-off to the pacer
    if (t_start) begin
      s_d.conv_pend = 1'b0;
    end
    // event wins over a release in the same cycle
    if (t_done || i_event) begin
      s_d.int_low = 1'b1;
    end
    // power-up check: wait until the synchroniser holds real pin samples,
    // so its reload value after reset never passes for a high line
    s_d.pin_sync = {s_q.pin_sync[0], i_int_pin};
    if (!s_q.pwrup_done && s_q.pwrup_age != PWRUP_SETTLE) begin
      s_d.pwrup_age = s_q.pwrup_age + 2'h1;
    end else if (!s_q.pwrup_done) begin
      s_d.pwrup_done = 1'b1;
      s_d.low_power_ok = s_q.pin_sync[1]; // R8
    end
  end

  // register the whole state; the pin synchroniser settles two edges in
  // the synchroniser reloads high, the power-up verdict waits it out
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s_q <= '0;
      s_q.scale <= IRAC_SCALE_RST; // R4
      s_q.options <= IRAC_OPT_RST;
      s_q.recovery <= IRAC_REC_RST;
      s_q.pin_sync <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  // readys drop while a half is held or an answer waits
  assign o_s_axi_awready = !s_q.aw_have && !s_q.bvalid;
  assign o_s_axi_wready = !s_q.w_have && !s_q.bvalid;
  // answers come straight from flops
  assign o_s_axi_bvalid = s_q.bvalid;
  assign o_s_axi_bresp = s_q.bresp;
  assign o_s_axi_arready = !s_q.rvalid;
  assign o_s_axi_rvalid = s_q.rvalid;
  assign o_s_axi_rdata = s_q.rdata;
  assign o_s_axi_rresp = s_q.rresp;
  // open drain: data always low, enable active low pulls the line
  assign o_int_pin = 1'b0; // R7
  assign o_int_pin_oe_n = !s_q.int_low; // R7
  // configuration fields to the measurement path
  assign o_high_range = s_q.options[IRAC_RANGE_BIT]; // R5
  assign o_scale = s_q.scale[IRAC_SCALE_W-1:0]; // R1
  // pacer status
  assign o_conv_busy = t_busy;
  assign o_conv_done = t_done;
  assign o_low_power_ok = s_q.low_power_ok;

  // ==========================================================
  // checks
  // ==========================================================
  a_scale_reset_zero: assert property (@(posedge i_clk_sys) i_reset |=> o_scale == '0) // R4
    else $error("scale not zero after reset");
  a_scale_write_lands: assert property (@(posedge i_clk_sys) disable iff (i_reset) // R2
    (s_q.aw_have && s_q.w_have && s_q.wreq.strb[0] && waddr == IRAC_ADDR_SCALE && scale_present)
    |=> o_scale == $past(wdata[2:0]))
    else $error("scale write not stored");
  a_range_write_lands: assert property (@(posedge i_clk_sys) disable iff (i_reset) // R5
    (s_q.aw_have && s_q.w_have && s_q.wreq.strb[0] && waddr == IRAC_ADDR_OPTIONS)
    |=> o_high_range == $past(wdata[IRAC_RANGE_BIT]))
    else $error("range select not stored");
  a_pin_never_high: assert property (@(posedge i_clk_sys) o_int_pin == 1'b0) // R7
    else $error("interrupt pin driven high");
  a_done_pulls_pin: assert property (@(posedge i_clk_sys) disable iff (i_reset) // R7
    t_done |=> !o_int_pin_oe_n)
    else $error("finished conversion did not pull pin");
  a_conv_short_min: assert property (@(posedge i_clk_sys) disable iff (i_reset) // R1
    $rose(t_busy) |-> t_busy [*2])
    else $error("conversion shorter than two cycles");
  a_scale_revision: assert property (@(posedge i_clk_sys) disable iff (i_reset) // R3
    !scale_present |-> o_scale == '0)
    else $error("scale set on early revision");
  a_power_up_check: assert property (@(posedge i_clk_sys) disable iff (i_reset) // R8
    $rose(s_q.pwrup_done) |-> o_low_power_ok == $past(s_q.pin_sync[1]))
    else $error("power-up pin level not captured");

  // ==========================================================
  // bus, pacer, field and pin checks
  // ==========================================================
  // a held address and data pair is answered on the next edge
  a_write_answers: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (s_q.aw_have && s_q.w_have) |=> o_s_axi_bvalid)
    else $error("write not answered");
  // an accepted read address returns data one edge later
  a_read_answers: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_s_axi_arvalid && o_s_axi_arready) |=> o_s_axi_rvalid)
    else $error("read not answered");
  // a queued request must reach the pacer, or conversions stall
  a_start_runs: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    t_start |=> t_busy && !s_q.conv_pend)
    else $error("queued conversion did not start");
  // reserved scale bits never hold a one, whatever the host wrote
  a_scale_upper_zero: assert property (@(posedge i_clk_sys) disable iff (i_reset) // R2
    s_q.scale[7:IRAC_SCALE_W] == '0)
    else $error("reserved scale bits set");
  // recovery keeps only its three-bit field
  a_recovery_field: assert property (@(posedge i_clk_sys) disable iff (i_reset) // R9
    (s_q.recovery & ~IRAC_REC_MASK) == 8'h00)
    else $error("recovery bits outside field set");
  // an event sinks the line on the next edge, even against a release
  a_event_pulls_pin: assert property (@(posedge i_clk_sys) disable iff (i_reset) // R7
    i_event |=> !o_int_pin_oe_n)
    else $error("event did not pull pin");
  // the line is let go through reset so the pull-up can win at power-up
  a_reset_releases: assert property (@(posedge i_clk_sys) // R8
    i_reset |=> o_int_pin_oe_n)
    else $error("pin sunk after reset");
  // the power-up verdict waits for two synchronised pin samples
  a_power_up_settle: assert property (@(posedge i_clk_sys) disable iff (i_reset) // R8
    $rose(s_q.pwrup_done) |-> $past(s_q.pwrup_age) == PWRUP_SETTLE)
    else $error("power-up verdict taken too early");

endmodule

// ---- rtl/irac_pkg.sv ----
/*
  package for the ir ambient adc configuration block: register offsets,
  field positions, reset values, timing figures and the bus carrier types.
  assumes a 32-bit axi4-lite register bus and a 100 MHz system clock.
*/
package irac_pkg;

  // ==========================================================
  // register map (byte addresses, one word each)
  // ==========================================================
  localparam logic [7:0] IRAC_IDX_SCALE = 8'h1e; // ir_integration_scale_param index
  localparam logic [7:0] IRAC_IDX_OPTIONS = 8'h1f; // ir_conversion_options_param index
  localparam logic [7:0] IRAC_IDX_RECOVERY = 8'h1d; // recovery period index
  localparam logic [7:0] IRAC_IDX_STATUS = 8'h20; // own status word index
  localparam logic [9:0] IRAC_ADDR_SCALE = {IRAC_IDX_SCALE, 2'h0};
  localparam logic [9:0] IRAC_ADDR_OPTIONS = {IRAC_IDX_OPTIONS, 2'h0};
  localparam logic [9:0] IRAC_ADDR_RECOVERY = {IRAC_IDX_RECOVERY, 2'h0};
  localparam logic [9:0] IRAC_ADDR_STATUS = {IRAC_IDX_STATUS, 2'h0};

  // ==========================================================
  // fields and reset values
  // ==========================================================
  localparam int IRAC_SCALE_W = 3; // integration scale field width
  localparam logic [7:0] IRAC_SCALE_MASK = 8'h07; // bits 2:0 writable
  localparam logic [7:0] IRAC_SCALE_RST = 8'h00; // divide by one
  localparam int IRAC_RANGE_BIT = 5; // high range select position
  localparam logic [7:0] IRAC_OPT_RANGE_MASK = 8'h20; // range select bit
  localparam logic [7:0] IRAC_OPT_RST = 8'h00; // reserved fields kept as zero
  localparam logic [7:0] IRAC_REC_MASK = 8'h70; // recovery field bits 6:4
  localparam logic [7:0] IRAC_REC_RST = 8'h70; // recovery reset value
  localparam int IRAC_REC_LSB = 4; // recovery field lsb
  localparam logic [3:0] IRAC_SEQ_REV_A03 = 4'h3; // first revision with the scale parameter

  // ==========================================================
  // timing
  // ==========================================================
  localparam int IRAC_CLK_MHZ = 100; // system clock rate
  localparam int IRAC_ADC_CLK_NS = 50; // base adc clock period
  localparam int IRAC_ADC_DIV = (IRAC_ADC_CLK_NS * IRAC_CLK_MHZ + 999) / 1000; // cycles per adc clock, rounded up

  // ==========================================================
  // axi responses and carriers
  // ==========================================================
  localparam logic [1:0] IRAC_RESP_OKAY = 2'h0;
  localparam logic [1:0] IRAC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [9:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } irac_wreq_type;

  typedef enum logic [1:0] {
    IRAC_IDLE,
    IRAC_RECOVER,
    IRAC_INTEGRATE
  } irac_phase_type;

endpackage

// ---- rtl/irac_conv_timer.sv ----
/*
  conversion timer: paces one ir ambient conversion as a recovery period
  followed by an integration window, both stretched by 2^scale adc clocks.
  assumes configuration stays steady or is sampled at each start.
*/
`timescale 1ns/10ps
module irac_conv_timer import irac_pkg::*; #(
  parameter int SCALE_W = IRAC_SCALE_W,
  parameter int CNT_W = 24
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [SCALE_W-1:0] i_scale,
  input wire logic [2:0] i_recovery,
  output logic o_busy,
  output logic o_recovering,
  output logic o_done
);

  // ==========================================================
  // state
  // ==========================================================
  typedef struct packed {
    irac_phase_type phase; // current conversion phase
    logic [CNT_W-1:0] cnt; // cycles left in phase
    logic [SCALE_W-1:0] scale; // scale captured at start
    logic done; // one-cycle end marker
  } irac_tmr_type;

  irac_tmr_type s_q;
  irac_tmr_type s_d;

  // cycles for n adc clocks stretched by 2^scale
  function automatic logic [CNT_W-1:0] stretch(input logic [CNT_W-1:0] n, input logic [SCALE_W-1:0] sc);
    logic [CNT_W-1:0] base;
    base = n * CNT_W'(IRAC_ADC_DIV);
    return base << sc;
  endfunction

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    unique case (s_q.phase)
      IRAC_IDLE: begin
        if (i_start) begin
          // recovery is 2^(code+2)-1 adc clocks, code 0 meaning one
          s_d.phase = IRAC_RECOVER;
          s_d.scale = i_scale;
          // sum widened to four bits, else codes 6 and 7 wrap to short counts
          s_d.cnt = stretch((i_recovery == 3'h0) ? CNT_W'(1) : ((CNT_W'(1) << (4'(i_recovery) + 4'h2)) - CNT_W'(1)),
                            i_scale) - CNT_W'(1);
        end
      end
      IRAC_RECOVER: begin
        if (s_q.cnt == '0) begin
          // integration window lengthened by 2^scale
          s_d.phase = IRAC_INTEGRATE; // R1
          s_d.cnt = stretch(CNT_W'(1), s_q.scale) - CNT_W'(1); // R1
        end else begin
          s_d.cnt = s_q.cnt - CNT_W'(1);
        end
      end
      IRAC_INTEGRATE: begin
        if (s_q.cnt == '0) begin
          s_d.phase = IRAC_IDLE;
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - CNT_W'(1);
        end
      end
    endcase
  end

  // register the whole state
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s_q <= '{phase: IRAC_IDLE, cnt: '0, scale: '0, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_busy = (s_q.phase != IRAC_IDLE);
  assign o_recovering = (s_q.phase == IRAC_RECOVER);
  assign o_done = s_q.done;

endmodule

// ---- verification/irac_pin_model.sv ----
/*
  host-side model of the interrupt line: external pull-up plus a
  host that can sink the line, e.g. to break the power-up condition.
  assumes the device touches the line only through its open-drain enable.
*/
`timescale 1ns/10ps
module irac_pin_model (
  input wire logic i_drive, // device output level, expected always low
  input wire logic i_oe_n, // device enable, low while sinking
  input wire logic i_hold_low, // host sinks the line on command
  output logic o_line // resolved wire level
);
  // ==========================================================
  // line resolution
  // ==========================================================
  // pulled up unless a party sinks it; a driven high never wins
  assign o_line = ((!i_oe_n && !i_drive) || i_hold_low) ? 1'b0 : 1'b1;
endmodule

// ---- verification/irac_top_test.sv ----
/*
  self-checking bench for irac_top: axi4-lite register tasks, reset
  values, scale codes, range select, unmapped access, conversion
  timing and the open-drain interrupt line.
  assumes the pin model as the only other party on the interrupt line.
*/
`timescale 1ns/10ps
module irac_top_test import irac_pkg::*;;
  // ==========================================================
  // signals
  // ==========================================================
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, ev, hold_low;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, int_drv, int_oe_n;
  logic hi_rng, busy, done, lp_ok, line;
  logic [1:0] bresp, rresp, r;
  logic [IRAC_SCALE_W-1:0] scale;
  int mismatches = 0;
  int n_tests = 0;
  int busy_cnt = 0; // cycles seen busy, for timing checks
  int i;

  irac_top u_irac_top (.i_clk_sys(clk), .i_reset(rst), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .i_event(ev), .i_int_pin(line), .o_int_pin(int_drv),
    .o_int_pin_oe_n(int_oe_n), .o_high_range(hi_rng), .o_scale(scale),
    .o_conv_busy(busy), .o_conv_done(done), .o_low_power_ok(lp_ok));

  irac_pin_model u_irac_pin_model (.i_drive(int_drv), .i_oe_n(int_oe_n),
    .i_hold_low(hold_low), .o_line(line));

  // ==========================================================
  // clock and busy counter
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // counts only known-high busy, so an x never inflates the figure
  always @(posedge clk) begin
    if (busy === 1'b1) begin
      busy_cnt <= busy_cnt + 1;
    end
  end

  // ==========================================================
  // reporting
  // ==========================================================
  task automatic end_sim;
    $display("counts: %0d mismatches in %0d comparisons", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // a spent wait bound counts as a mismatch and ends the run
  task automatic tmo;
    mismatches++;
    end_sim();
  endtask

  // ==========================================================
  // axi4-lite master tasks
  // ==========================================================
  // starts one edge late so a strobe is never assigned twice per step
  task automatic wr(input logic [9:0] a, input logic [31:0] dat);
    int n;
    logic got;
    @(posedge clk);
    got = 1'b0;
    awaddr <= a;
    wdata <= dat;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100 && !got; n++) begin
      @(posedge clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        got = 1'b1;
        r = bresp;
        bready <= 1'b0;
      end
    end
    if (!got) tmo();
  endtask

  task automatic rd(input logic [9:0] a);
    int n;
    logic got;
    @(posedge clk);
    got = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100 && !got; n++) begin
      @(posedge clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        got = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    if (!got) tmo();
  endtask

  // one conversion: busy length, then the line sunk and released
  task automatic conv(input logic [2:0] s, input logic [2:0] c, input int cyc);
    int n;
    int b0;
    wr(IRAC_ADDR_SCALE, {29'h0, s});
    wr(IRAC_ADDR_RECOVERY, {25'h0, c, 4'h0});
    b0 = busy_cnt;
    wr(IRAC_ADDR_STATUS, 32'h1);
    for (n = 0; n < 5000 && done !== 1'b1; n++) @(posedge clk);
    if (n >= 5000) tmo();
    repeat (2) @(posedge clk);
    chk(busy_cnt - b0, cyc);
    chk(int_oe_n, 1'b0);
    chk(int_drv, 1'b0);
    rd(IRAC_ADDR_STATUS);
    chk(d & 32'hc, 32'hc);
    wr(IRAC_ADDR_STATUS, 32'h2);
    repeat (2) @(posedge clk);
    chk(int_oe_n, 1'b1);
    chk(line, 1'b1);
  endtask

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, ev, hold_low} = 7'h00;
    awaddr = 10'h000;
    araddr = 10'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // reset values
    rd(IRAC_ADDR_SCALE);
    chk(d, 32'h0);
    chk(r, IRAC_RESP_OKAY);
    chk(scale, 3'h0);
    rd(IRAC_ADDR_OPTIONS);
    chk(d, 32'h0);
    rd(IRAC_ADDR_RECOVERY);
    chk(d, 32'h70);
    chk(lp_ok, 1'b1);
    // every scale code, reserved bits written high
    for (i = 0; i < 8; i++) begin
      wr(IRAC_ADDR_SCALE, 32'hf8 | 32'(i));
      rd(IRAC_ADDR_SCALE);
      chk(d, 32'(i));
      chk(scale, i[2:0]);
    end
    // range select by read-modify-write
    rd(IRAC_ADDR_OPTIONS);
    wr(IRAC_ADDR_OPTIONS, d | 32'h20);
    chk(hi_rng, 1'b1);
    rd(IRAC_ADDR_OPTIONS);
    chk(d, 32'h20);
    wr(IRAC_ADDR_OPTIONS, d & ~32'h20);
    chk(hi_rng, 1'b0);
    // unmapped place, both directions
    rd(10'h3fc);
    chk(r, IRAC_RESP_SLVERR);
    chk(d, 32'h0);
    wr(10'h3fc, 32'h1);
    chk(r, IRAC_RESP_SLVERR);
    // shortest count, then recovery as complement of scale
    conv(3'h0, 3'h0, 10);
    conv(3'h3, 3'h4, 2560);
    conv(3'h0, 3'h7, 2560);
    // external event sinks the line
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    repeat (3) @(posedge clk);
    chk(int_oe_n, 1'b0);
    wr(IRAC_ADDR_STATUS, 32'h2);
    repeat (2) @(posedge clk);
    chk(int_oe_n, 1'b1);
    // line held low through power-up: no low-power operation
    hold_low <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // verdict lands on the third edge after release; look past it
    repeat (5) @(posedge clk);
    chk(lp_ok, 1'b0);
    end_sim();
  end
endmodule
